// File: logic/ncc_common_regs.v
// Summary of operation
// RULE_01: Writing 1 to mode bit 7 reinitialises the bank and the bit clears itself when that reset ends.
// RULE_02: While mode bit 4 is set incoming ping requests get no reply, otherwise replies go out; the code also sends no reply during a soft reset.
// RULE_03: Mode bit 3 turns point-to-point-over-Ethernet operation on when 1 and off when 0.
// RULE_04: The mode register sits at index 0xFE0000, is read-write and resets to zero.
// RULE_05: The gateway address takes indexes 0xFE0001 to 0xFE0004, first octet lowest, reset zero.
// RULE_06: The subnet mask takes indexes 0xFE0005 to 0xFE0008, top octet lowest, reset zero.
// RULE_07: The source hardware address takes indexes 0xFE0009 to 0xFE000E, first octet lowest, reset zero.
// RULE_08: The source IP address takes indexes 0xFE000F to 0xFE0012, first octet lowest, reset zero.
// RULE_09: Mode bits 6, 5, 2, 1 and 0 read as zero and software writes zero to them.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "ncc_map.vh"

module ncc_common_regs #(
  parameter integer SRST_CYCLES = `NCC_SRST_CYCLES
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        echo_request,
  output reg         echo_reply_go,
  output wire        ping_block,
  output wire        pppoe_enable,
  output wire        core_soft_reset,
  output wire [31:0] gateway_address,
  output wire [31:0] subnet_mask,
  output wire [47:0] source_mac_address,
  output wire [31:0] source_ip_address
);

  localparam integer NB = `NCC_NUM_BYTES;

  // Byte store; slot 0 is the mode register
  reg  [7:0]  mem_r [0:NB-1];
  reg  [7:0]  drop_cnt_r;
  reg  [7:0]  drop_cnt_nxt;
  reg  [31:0] rd_nxt;
  reg         err_nxt;
  wire [29:0] idx;
  wire        setup;
  wire        access_done;
  wire        wr_ok;
  wire        srst_busy;
  wire        srst_start;
  integer     i;

  assign idx         = paddr[31:2];
  assign setup       = psel && !penable;
  assign access_done = psel && penable && pready;

  // Index falls in the configuration byte bank
  function in_bank;
    input [29:0] a;
    begin
      in_bank = (a >= `NCC_IDX_MODE) && (a <= `NCC_IDX_IP_LAST);
    end
  endfunction

  // Slot number inside the byte bank
  function [4:0] slot_of;
    input [29:0] a;
    reg   [29:0] d;
    begin
      d       = a - `NCC_IDX_MODE;
      slot_of = d[4:0];
    end
  endfunction

  // Any address the slave answers without error
  function mapped;
    input [29:0] a;
    input [1:0]  lo;
    begin
      mapped = (lo == 2'b00) &&
               (in_bank(a) || a == `NCC_IDX_DROP_CNT);
    end
  endfunction

  // Read view of one byte; mode bit 7 shows the soft reset in progress
  function [7:0] rd_byte;
    input [29:0] a;
    input [7:0]  mode;
    input [7:0]  val;
    input [7:0]  drops;
    input        busy;
    begin
      if (a == `NCC_IDX_MODE) begin
        rd_byte = (mode & `NCC_MODE_WR_MASK) |
                  {busy, 7'h00}; // [RULE_01] [RULE_09]
      end else if (a == `NCC_IDX_DROP_CNT) begin
        rd_byte = drops;
      end else begin
        rd_byte = val;
      end
    end
  endfunction

  // Decode in the setup phase so the access phase completes at once
  always @* begin
    rd_nxt  = 32'h00000000;
    err_nxt = 1'b0;
    if (setup) begin
      err_nxt = !mapped(idx, paddr[1:0]);
      if (!pwrite && !err_nxt) begin
        rd_nxt[7:0] = rd_byte(idx, mem_r[0],
                              mem_r[slot_of(idx)],
                              drop_cnt_r, srst_busy);
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= err_nxt;
      prdata  <= rd_nxt;
    end
  end

  // Writes land on the completing edge; ignored during soft reset
  assign wr_ok = access_done && pwrite && !pslverr && !srst_busy;

  assign srst_start = wr_ok && idx == `NCC_IDX_MODE &&
                      pwdata[`NCC_MODE_RST_BIT]; // [RULE_01]

  ncc_srst_seq #(
    .CYCLES (SRST_CYCLES),
    .CW     (8)
  ) u_srst (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (srst_start),
    .busy_r  (srst_busy),
    .done_r  ()
  );

  // Byte bank; every byte resets to zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_r[0] <= `NCC_MODE_RESET; // [RULE_04]
      for (i = 1; i < NB; i = i + 1) begin
        mem_r[i] <= `NCC_BYTE_RESET; // [RULE_05] [RULE_06] [RULE_07] [RULE_08]
      end
    end else if (srst_start || srst_busy) begin
      // Held at reset values for the whole soft reset
      for (i = 0; i < NB; i = i + 1) begin
        mem_r[i] <= `NCC_BYTE_RESET; // [RULE_01]
      end
    end else if (wr_ok && in_bank(idx)) begin
      if (idx == `NCC_IDX_MODE) begin
        // Reserved bits never stored, so they read back as zero
        mem_r[0] <= pwdata[7:0] & `NCC_MODE_WR_MASK; // [RULE_04] [RULE_09]
      end else begin
        mem_r[slot_of(idx)] <= pwdata[7:0]; // [RULE_05] [RULE_06] [RULE_07] [RULE_08]
      end
    end
  end

  // Mode controls: ping block and PPPoE straight from the stored bits, soft reset from the sequencer busy flag
  assign ping_block      = mem_r[0][`NCC_MODE_PB_BIT];
  assign pppoe_enable    = mem_r[0][`NCC_MODE_PPPOE_BIT]; // [RULE_03]
  assign core_soft_reset = srst_busy;

  // Lowest index carries the most significant octet
  assign gateway_address    = {mem_r[1], mem_r[2],
                               mem_r[3], mem_r[4]}; // [RULE_05]
  assign subnet_mask        = {mem_r[5], mem_r[6],
                               mem_r[7], mem_r[8]}; // [RULE_06]
  assign source_mac_address = {mem_r[9],  mem_r[10], mem_r[11],
                               mem_r[12], mem_r[13], mem_r[14]}; // [RULE_07]
  assign source_ip_address  = {mem_r[15], mem_r[16],
                               mem_r[17], mem_r[18]}; // [RULE_08]

  // Saturates rather than wraps so a flood is not mistaken for quiet
  always @* begin
    drop_cnt_nxt = drop_cnt_r;
    if (echo_request && (ping_block || srst_busy) &&
        drop_cnt_r != 8'hff) begin
      drop_cnt_nxt = drop_cnt_r + 8'h01;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      echo_reply_go <= 1'b0;
      drop_cnt_r    <= `NCC_DROP_RESET;
    end else begin
      // A request during soft reset is dropped too
      echo_reply_go <= echo_request && !ping_block &&
                       !srst_busy; // [RULE_02]
      if (srst_start) begin
        drop_cnt_r <= `NCC_DROP_RESET; // [RULE_01]
      end else begin
        drop_cnt_r <= drop_cnt_nxt;
      end
    end
  end

endmodule

`default_nettype wire

// File: logic/ncc_map.vh
`ifndef NCC_MAP_VH
`define NCC_MAP_VH

// Register indexes (byte address = 4 * index)
`define NCC_IDX_MODE      30'h00fe0000
`define NCC_IDX_GW_FIRST  30'h00fe0001
`define NCC_IDX_GW_LAST   30'h00fe0004
`define NCC_IDX_SUB_FIRST 30'h00fe0005
`define NCC_IDX_SUB_LAST  30'h00fe0008
`define NCC_IDX_MAC_FIRST 30'h00fe0009
`define NCC_IDX_MAC_LAST  30'h00fe000e
`define NCC_IDX_IP_FIRST  30'h00fe000f
`define NCC_IDX_IP_LAST   30'h00fe0012
`define NCC_IDX_DROP_CNT  30'h00fe0013

// Number of byte slots in the bank, mode register included
`define NCC_NUM_BYTES     19

// Mode register fields
`define NCC_MODE_RST_BIT   7
`define NCC_MODE_PB_BIT    4
`define NCC_MODE_PPPOE_BIT 3
`define NCC_MODE_WR_MASK   8'h18

// Reset values
`define NCC_MODE_RESET     8'h00
`define NCC_BYTE_RESET     8'h00
`define NCC_DROP_RESET     8'h00

// Soft reset duration
`define NCC_CLK_PERIOD_NS  4
`define NCC_SRST_TIME_NS   64
`define NCC_SRST_CYCLES    ((`NCC_SRST_TIME_NS) / (`NCC_CLK_PERIOD_NS))

`endif

// File: logic/ncc_srst_seq.v
`timescale 1ns/1ps
`default_nettype none
`include "ncc_map.vh"

module ncc_srst_seq #(
  parameter integer CYCLES = `NCC_SRST_CYCLES,
  parameter integer CW     = 8
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          start,
  output reg           busy_r,
  output reg           done_r
);

  reg [CW-1:0] cnt_r;
  reg [CW-1:0] cnt_nxt;

  localparam integer  LAST_I = CYCLES - 1;
  localparam [CW-1:0] LAST   = LAST_I[CW-1:0];

  always @* begin
    cnt_nxt = cnt_r;
    if (start && !busy_r) begin
      cnt_nxt = {CW{1'b0}};
    end else if (busy_r) begin
      cnt_nxt = cnt_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Busy spans exactly CYCLES clocks, then a one-cycle done pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= {CW{1'b0}};
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      done_r <= 1'b0;
      if (start && !busy_r) begin
        busy_r <= 1'b1;
      end else if (busy_r && cnt_r == LAST) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// File: bench/ncc_common_props.sv
`timescale 1ns/1ps
`default_nettype none
module ncc_common_props #(
  parameter integer SRST_CYCLES = 16
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        echo_request,
  input wire logic        echo_reply_go,
  input wire logic        ping_block,
  input wire logic        pppoe_enable,
  input wire logic        core_soft_reset,
  input wire logic [31:0] gateway_address,
  input wire logic [31:0] subnet_mask,
  input wire logic [47:0] source_mac_address,
  input wire logic [31:0] source_ip_address
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_done;
    psel && penable && pready;
  endsequence
  sequence s_mode_wr;
    s_done ##0 pwrite && paddr == 32'h03f80000 && !core_soft_reset;
  endsequence
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_ping_set: assert property (
    s_mode_wr ##0 !pwdata[7] |=> ping_block == $past(pwdata[4]))
    else $error("ping block bit not stored");
  a_pppoe_set: assert property (
    s_mode_wr ##0 !pwdata[7] |=> pppoe_enable == $past(pwdata[3]))
    else $error("pppoe bit not stored");
  a_srst_start: assert property (s_mode_wr ##0 pwdata[7] |=>
    core_soft_reset && gateway_address == 0 && source_mac_address == 0)
    else $error("soft reset did not start");
  a_srst_len: assert property ($fell(core_soft_reset) |->
    $past(core_soft_reset, SRST_CYCLES) &&
    !$past(core_soft_reset, SRST_CYCLES + 1))
    else $error("soft reset length wrong");
  a_echo_reply: assert property (
    echo_request && !ping_block && !core_soft_reset |=> echo_reply_go)
    else $error("echo reply missing");
  a_echo_block: assert property (
    echo_request && ping_block |=> !echo_reply_go)
    else $error("echo reply while blocked");
  a_mode_rsvd: assert property (s_done ##0 !pwrite &&
    paddr == 32'h03f80000 |-> prdata[6:5] == 0 && prdata[2:0] == 0)
    else $error("reserved mode bits set");
endmodule
bind ncc_common_regs ncc_common_props #(.SRST_CYCLES(SRST_CYCLES))
  i_ncc_common_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .echo_request(echo_request), .echo_reply_go(echo_reply_go),
  .ping_block(ping_block), .pppoe_enable(pppoe_enable),
  .core_soft_reset(core_soft_reset), .gateway_address(gateway_address),
  .subnet_mask(subnet_mask), .source_mac_address(source_mac_address),
  .source_ip_address(source_ip_address));
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, echo_request, er;
  logic [31:0] paddr, pwdata;
  logic [7:0]  rd;
  wire  [31:0] prdata, gw, sub, ip;
  wire  [47:0] mac;
  wire         pready, pslverr, echo_reply_go, ping_block, pppoe, csr;
  int          err_count, comparisons, cyc;
  localparam int SRST = 2;
  // Short soft reset keeps the run brief
  ncc_common_regs #(.SRST_CYCLES(SRST)) i_ncc_common_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .echo_request(echo_request),
    .echo_reply_go(echo_reply_go), .ping_block(ping_block),
    .pppoe_enable(pppoe), .core_soft_reset(csr), .gateway_address(gw),
    .subnet_mask(sub), .source_mac_address(mac), .source_ip_address(ip));
  function automatic [31:0] ad(input int i);
    ad = 32'h03f80000 + 32'(i) * 32'h4;
  endfunction
  task summarize;
    $display("errors %0d checks %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input string n, input logic [47:0] s, input logic [47:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= 32'(d);
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0]; er = pslverr; psel <= 0; penable <= 0;
  endtask
  task echo(input logic e);
    @(posedge pclk) echo_request <= 1;
    @(posedge pclk) echo_request <= 0;
    @(posedge pclk) chk("reply", echo_reply_go, e);
  endtask
  task t_reset;
    for (int i = 0; i < 19; i++) begin
      apb(0, ad(i), 0);
      chk("reset byte", rd, 0);
    end
    chk("reset ports", {gw, sub}, 0);
  endtask
  task t_bytes;
    for (int i = 1; i < 19; i++) apb(1, ad(i), 8'(8'h30 + i));
    for (int i = 1; i < 19; i++) begin
      apb(0, ad(i), 0);
      chk("byte", rd, 8'(8'h30 + i));
    end
    chk("gateway", gw, 32'h31323334);
    chk("mask", sub, 32'h35363738);
    chk("mac", mac, 48'h393a3b3c3d3e);
    chk("ip", ip, 32'h3f404142);
  endtask
  task t_mode;
    apb(1, ad(0), 8'h18);
    apb(0, ad(0), 0);
    chk("mode", rd, 8'h18);
    chk("ping on", ping_block, 1);
    echo(0);
    apb(0, ad(19), 0);
    chk("drops", rd, 1);
    apb(1, ad(0), 8'h08);
    echo(1);
    chk("pppoe on", pppoe, 1);
    apb(1, ad(0), 8'h00);
    apb(0, ad(0), 0);
    chk("pppoe off", {rd, pppoe}, 0);
  endtask
  task t_srst;
    int n;
    apb(1, ad(0), 8'h18);
    apb(1, ad(0), 8'h98);
    @(posedge pclk);
    chk("srst busy", csr, 1);
    for (n = 0; csr === 1'b1 && n < 10; n++) @(posedge pclk);
    chk("srst end", csr, 0);
    chk("srst len", n, SRST);
    apb(0, ad(0), 0);
    chk("mode after", rd, 0);
    apb(0, ad(19), 0);
    chk("drops after", rd, 0);
    chk("bank after", {gw[7:0], mac[47:40], ip[7:0], pppoe}, 0);
  endtask
  task t_hwrst;
    apb(1, ad(1), 8'h5a);
    apb(1, ad(0), 8'h18);
    @(posedge pclk) presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(0, ad(0), 0);
    chk("hw reset mode", {rd, ping_block}, 0);
    apb(0, ad(1), 0);
    chk("hw reset gw", {rd, gw}, 0);
  endtask
  task t_err;
    apb(0, 32'h03f80050, 0);
    chk("unmapped", {er, rd}, 9'h100);
    apb(1, 32'h03f80006, 8'h55);
    chk("misaligned", er, 1);
    apb(0, ad(1), 0);
    chk("no write", rd, 0);
  endtask
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      summarize;
    end
  end
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; echo_request = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_bytes;
    t_mode;
    t_srst;
    t_err;
    t_hwrst;
    summarize;
  end
endmodule
`default_nettype wire
